/* rtl/fpid_pkg.sv */
// Constants, types and shared decoding for the flash power-down and identify link.
// Assumes a 100 MHz system clock at both ends and a host-made serial clock.
package fpid_pkg;

	// ----------------------------------------------------------------
	// Opcodes and fixed header values
	// ----------------------------------------------------------------
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_WAKE_ID = 8'hAB;
	localparam logic [7:0] OP_MFG_ID = 8'h90;
	localparam logic [7:0] OP_MFG_ID_DUAL = 8'h92;
	localparam logic [7:0] OP_UNIQUE = 8'h4B;
	localparam logic [7:0] OP_STD_ID = 8'h9F;
	localparam logic [23:0] ADDR_SWAP = 24'h000001;
	localparam logic [7:0] CONTINUATION_MODE_BITS = 8'hF0;

	// ----------------------------------------------------------------
	// Header lengths in serial clocks
	// ----------------------------------------------------------------
	localparam logic [5:0] OPCODE_CLKS = 6'h08;
	localparam logic [5:0] DUAL_ADDR_END = 6'h14;
	localparam logic [5:0] SINGLE_ADDR_END = 6'h20;
	localparam logic [5:0] HDR_DUAL = 6'h18;
	localparam logic [5:0] HDR_UNIQUE = 6'h28;
	localparam logic [5:0] CNT_SAT = 6'h3F;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int DLY_W = 12;
	localparam int SLEEP_ENTRY_DELAY_NS = 3000;
	localparam int WAKE_DELAY_NS = 3000;
	localparam int WAKE_WITH_IDENTIFY_DELAY_NS = 3500;
	// Entry is a longest time, so it rounds down; wake times round up
	localparam logic [DLY_W-1:0] SLEEP_ENTRY_CYC = DLY_W'(SLEEP_ENTRY_DELAY_NS * CLK_MHZ / 1000);
	localparam logic [DLY_W-1:0] WAKE_CYC = DLY_W'((WAKE_DELAY_NS * CLK_MHZ + 999) / 1000);
	localparam logic [DLY_W-1:0] WAKE_ID_CYC =
		DLY_W'((WAKE_WITH_IDENTIFY_DELAY_NS * CLK_MHZ + 999) / 1000);
	// Covers the receiver's synchroniser so it sees every high phase
	localparam logic [DLY_W-1:0] CS_HIGH_MIN_CYC = 12'h008;

	typedef enum logic [1:0] {PWR_NORMAL, PWR_ENTERING, PWR_ASLEEP, PWR_WAKING} fpid_pwr_e;
	typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} fpid_host_e;

	// ----------------------------------------------------------------
	// Shared decoding
	// ----------------------------------------------------------------
	function automatic logic fpid_is_dual(input logic [7:0] op);
		return op == OP_MFG_ID_DUAL;
	endfunction : fpid_is_dual

	function automatic logic [5:0] fpid_hdr_clks(input logic [7:0] op);
		case (op)
			OP_WAKE_ID, OP_MFG_ID: return SINGLE_ADDR_END;
			OP_MFG_ID_DUAL: return HDR_DUAL;
			OP_UNIQUE: return HDR_UNIQUE;
			default: return OPCODE_CLKS;
		endcase
	endfunction : fpid_hdr_clks

endpackage : fpid_pkg

/* rtl/fpid_if.sv */
// Serial link between the flash identify logic and its host.
// Assumes idle lines float high through pull-ups modelled here.
`timescale 1ns/100ps
interface fpid_if;
	logic sclk;
	logic cs_n;
	logic h_io0_o;
	logic h_io0_oe;
	logic h_io1_o;
	logic h_io1_oe;
	logic d_io0_o;
	logic d_io0_oe;
	logic d_io1_o;
	logic d_io1_oe;
	logic io0;
	logic io1;

	// Host drive wins; contention is a protocol fault, not resolved here
	assign io0 = h_io0_oe ? h_io0_o : (d_io0_oe ? d_io0_o : 1'h1);
	assign io1 = h_io1_oe ? h_io1_o : (d_io1_oe ? d_io1_o : 1'h1);

	modport dev (input sclk, input cs_n, input io0, input io1,
		output d_io0_o, output d_io0_oe, output d_io1_o, output d_io1_oe);
	modport host (output sclk, output cs_n, output h_io0_o, output h_io0_oe,
		output h_io1_o, output h_io1_oe, input io0, input io1);
endinterface : fpid_if

/* rtl/fpid_device.sv */
// Flash end: power-down entry and exit and the identification reads.
// Assumes busy comes from program and erase logic on the same clock.
`timescale 1ns/100ps
module fpid_device
	import fpid_pkg::*;
#(
	// Identity values below are arbitrary
	parameter logic [7:0] MANUF_ID = 8'h5A,
	parameter logic [7:0] DEVICE_ID = 8'h12,
	parameter logic [7:0] MEMORY_TYPE_BYTE = 8'h30,
	parameter logic [7:0] CAPACITY_BYTE = 8'h10,
	parameter logic [63:0] UNIQUE_ID = 64'h0123456789ABCDEF
) (
	input wire logic clock,
	input wire logic rst_n,
	fpid_if.dev link,
	input wire logic busy,
	output logic asleep,
	output logic ready,
	output logic busy_flag
);

	// ----------------------------------------------------------------
	// Response bytes
	// ----------------------------------------------------------------
	function automatic logic [7:0] resp_byte(input logic [7:0] op, input logic [2:0] idx,
		input logic swap);
		case (op)
			OP_WAKE_ID: return DEVICE_ID;
			OP_MFG_ID, OP_MFG_ID_DUAL: return (idx[0] ^ swap) ? DEVICE_ID : MANUF_ID;
			OP_UNIQUE: return UNIQUE_ID[8'(3'h7 - idx) * 8 +: 8];
			OP_STD_ID: begin
				case (idx)
					3'h0: return MANUF_ID;
					3'h1: return MEMORY_TYPE_BYTE;
					3'h2: return CAPACITY_BYTE;
					default: return 8'h00;
				endcase
			end
			default: return 8'h00;
		endcase
	endfunction : resp_byte

	function automatic logic is_read(input logic [7:0] op);
		return op == OP_WAKE_ID || op == OP_MFG_ID || op == OP_MFG_ID_DUAL ||
			op == OP_UNIQUE || op == OP_STD_ID;
	endfunction : is_read

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Bit order: sclk, cs_n, io1, io0
	logic [3:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;
	logic [1:0] prev_r, prev_nxt;

	always_comb begin
		sync1_nxt = {link.sclk, link.cs_n, link.io1, link.io0};
		sync2_nxt = sync1_r;
		prev_nxt = sync2_r[3:2];
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync1_r <= 4'hF;
			sync2_r <= 4'hF;
			prev_r <= 2'h3;
		end else begin
			sync1_r <= sync1_nxt;
			sync2_r <= sync2_nxt;
			prev_r <= prev_nxt;
		end
	end

	logic cs_low, sclk_rise, sclk_fall, cs_rise, in0, in1;
	always_comb begin
		cs_low = ~sync2_r[2];
		// Only edges seen while selected count, so either idle level works
		sclk_rise = sync2_r[3] & ~prev_r[1];
		sclk_fall = ~sync2_r[3] & prev_r[1];
		cs_rise = sync2_r[2] & ~prev_r[0];
		in1 = sync2_r[1];
		in0 = sync2_r[0];
	end

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	fpid_pwr_e pwr_r, pwr_nxt;
	logic [DLY_W-1:0] dly_r, dly_nxt;
	logic asleep_r, asleep_nxt, ready_r, ready_nxt, busy_r, busy_nxt;
	logic [5:0] rx_cnt_r, rx_cnt_nxt;
	logic [7:0] op_r, op_nxt;

	always_comb begin
		pwr_nxt = pwr_r;
		dly_nxt = dly_r;
		busy_nxt = busy;
		unique case (pwr_r)
			PWR_NORMAL: begin
				// Exactly eight clocks, else the request is dropped
				if (cs_rise && op_r == OP_SLEEP && rx_cnt_r == OPCODE_CLKS) begin
					pwr_nxt = PWR_ENTERING;
					dly_nxt = SLEEP_ENTRY_CYC - 12'h001;
				end
			end
			PWR_ENTERING: begin
				if (dly_r == '0) begin
					pwr_nxt = PWR_ASLEEP;
				end else begin
					dly_nxt = dly_r - 12'h001;
				end
			end
			PWR_ASLEEP: begin
				if (cs_rise && op_r == OP_WAKE_ID && rx_cnt_r >= OPCODE_CLKS && !busy_r) begin
					pwr_nxt = PWR_WAKING;
					// Clocks beyond the opcode mean the identifier was read
					dly_nxt = (rx_cnt_r == OPCODE_CLKS) ? WAKE_CYC - 12'h001 : WAKE_ID_CYC - 12'h001;
				end
			end
			PWR_WAKING: begin
				if (dly_r == '0) begin
					pwr_nxt = PWR_NORMAL;
				end else begin
					dly_nxt = dly_r - 12'h001;
				end
			end
		endcase
		asleep_nxt = pwr_nxt == PWR_ASLEEP;
		ready_nxt = pwr_nxt == PWR_NORMAL;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pwr_r <= PWR_NORMAL;
			dly_r <= '0;
			asleep_r <= 1'h0;
			ready_r <= 1'h1;
			busy_r <= 1'h0;
		end else begin
			pwr_r <= pwr_nxt;
			dly_r <= dly_nxt;
			asleep_r <= asleep_nxt;
			ready_r <= ready_nxt;
			busy_r <= busy_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Frame receive and transmit
	// ----------------------------------------------------------------
	logic [23:0] addr_r, addr_nxt;
	logic [5:0] tx_cnt_r, tx_cnt_nxt;
	logic d0_r, d0_nxt, d1_r, d1_nxt, oe0_r, oe0_nxt, oe1_r, oe1_nxt;
	logic dual, served, swap;
	logic [7:0] cur;
	logic [1:0] pidx;

	always_comb begin
		rx_cnt_nxt = rx_cnt_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		tx_cnt_nxt = tx_cnt_r;
		d0_nxt = d0_r;
		d1_nxt = d1_r;
		oe0_nxt = oe0_r;
		oe1_nxt = oe1_r;
		dual = fpid_is_dual(op_r);
		swap = addr_r == ADDR_SWAP;
		// While asleep only the wake opcode is decoded; wait phases decode nothing
		served = is_read(op_r) && (pwr_r == PWR_NORMAL ||
			(pwr_r == PWR_ASLEEP && op_r == OP_WAKE_ID && !busy_r));
		pidx = 2'h3 - tx_cnt_r[1:0];
		cur = dual ? resp_byte(op_r, tx_cnt_r[4:2], swap) : resp_byte(op_r, tx_cnt_r[5:3], swap);
		if (!cs_low) begin
			rx_cnt_nxt = '0;
			tx_cnt_nxt = '0;
			oe0_nxt = 1'h0;
			oe1_nxt = 1'h0;
		end else begin
			if (sclk_rise) begin
				if (rx_cnt_r < OPCODE_CLKS) begin
					op_nxt = {op_r[6:0], in0};
				end else if (dual && rx_cnt_r < DUAL_ADDR_END) begin
					addr_nxt = {addr_r[21:0], in1, in0};
				end else if (!dual && rx_cnt_r < SINGLE_ADDR_END) begin
					addr_nxt = {addr_r[22:0], in0};
				end
				rx_cnt_nxt = (rx_cnt_r == CNT_SAT) ? rx_cnt_r : rx_cnt_r + 6'h01;
			end
			if (sclk_fall && served && rx_cnt_r >= OPCODE_CLKS &&
				rx_cnt_r >= fpid_hdr_clks(op_r)) begin
				// Counter wraps, so reads repeat for as long as clocks run
				tx_cnt_nxt = tx_cnt_r + 6'h01;
				oe1_nxt = 1'h1;
				if (dual) begin
					oe0_nxt = 1'h1;
					d1_nxt = cur[{pidx, 1'h1}];
					d0_nxt = cur[{pidx, 1'h0}];
				end else begin
					d1_nxt = cur[3'h7 - tx_cnt_r[2:0]];
				end
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rx_cnt_r <= '0;
			op_r <= 8'h00;
			addr_r <= '0;
			tx_cnt_r <= '0;
			d0_r <= 1'h0;
			d1_r <= 1'h0;
			oe0_r <= 1'h0;
			oe1_r <= 1'h0;
		end else begin
			rx_cnt_r <= rx_cnt_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			d0_r <= d0_nxt;
			d1_r <= d1_nxt;
			oe0_r <= oe0_nxt;
			oe1_r <= oe1_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.d_io0_o = d0_r;
	assign link.d_io0_oe = oe0_r;
	assign link.d_io1_o = d1_r;
	assign link.d_io1_oe = oe1_r;
	assign asleep = asleep_r;
	assign ready = ready_r;
	assign busy_flag = busy_r;

endmodule : fpid_device

/* rtl/fpid_host.sv */
// Host end: makes the serial clock and runs one instruction per request.
// Assumes the user waits for idle before each request.
`timescale 1ns/100ps
module fpid_host
	import fpid_pkg::*;
#(
	parameter int DIV_HALF = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	fpid_if.host link,
	input wire logic req,
	input wire logic [7:0] req_op,
	input wire logic [23:0] req_addr,
	input wire logic [7:0] req_nbytes,
	output logic idle,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic done
);

	// Read data returns about five clocks after each falling edge, through both synchronisers
	if (DIV_HALF < 6 || DIV_HALF > 256) begin : g_chk
		$error("DIV_HALF must lie between 6 and 256");
	end

	localparam logic [7:0] DIV_LOAD = 8'(DIV_HALF - 1);

	// ----------------------------------------------------------------
	// Input synchroniser
	// ----------------------------------------------------------------
	logic [1:0] s1_r, s1_nxt, s2_r, s2_nxt;
	always_comb begin
		s1_nxt = {link.io1, link.io0};
		s2_nxt = s1_r;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s1_r <= 2'h3;
			s2_r <= 2'h3;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	fpid_host_e st_r, st_nxt;
	logic [7:0] div_r, div_nxt;
	logic [10:0] idx_r, idx_nxt, total_r, total_nxt;
	logic [39:0] hdr_r, hdr_nxt;
	logic [7:0] op_r, op_nxt, rx_r, rx_nxt, rd_r, rd_nxt;
	logic [2:0] rxb_r, rxb_nxt;
	logic [DLY_W-1:0] gap_r, gap_nxt;
	logic sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, o0_r, o0_nxt, o1_r, o1_nxt;
	logic oe0_r, oe0_nxt, oe1_r, oe1_nxt, idle_r, idle_nxt, val_r, val_nxt, done_r, done_nxt;
	logic dual, in_hdr_next;
	logic [39:0] shifted;

	always_comb begin
		st_nxt = st_r;
		div_nxt = (div_r == 8'h00) ? DIV_LOAD : div_r - 8'h01;
		idx_nxt = idx_r;
		total_nxt = total_r;
		hdr_nxt = hdr_r;
		op_nxt = op_r;
		rx_nxt = rx_r;
		rd_nxt = rd_r;
		rxb_nxt = rxb_r;
		gap_nxt = gap_r;
		sclk_nxt = sclk_r;
		cs_n_nxt = cs_n_r;
		o0_nxt = o0_r;
		o1_nxt = o1_r;
		oe0_nxt = oe0_r;
		oe1_nxt = oe1_r;
		val_nxt = 1'h0;
		done_nxt = 1'h0;
		dual = fpid_is_dual(op_r);
		in_hdr_next = (idx_r + 11'h001) < 11'(fpid_hdr_clks(op_r));
		// The last opcode bit still leaves by a single shift; pairs start after it
		shifted = (dual && idx_r >= 11'(OPCODE_CLKS)) ? {hdr_r[37:0], 2'h0} :
			{hdr_r[38:0], 1'h0};
		unique case (st_r)
			H_IDLE: begin
				div_nxt = DIV_LOAD;
				if (req) begin
					st_nxt = H_LOW;
					cs_n_nxt = 1'h0;
					op_nxt = req_op;
					// Mode bits FXh follow the address; elsewhere they are dummy clocks
					hdr_nxt = {req_op, req_addr, CONTINUATION_MODE_BITS};
					total_nxt = 11'(fpid_hdr_clks(req_op)) + (fpid_is_dual(req_op) ?
						{1'h0, req_nbytes, 2'h0} : {req_nbytes, 3'h0});
					idx_nxt = '0;
					rxb_nxt = '0;
					o0_nxt = req_op[7];
					oe0_nxt = 1'h1;
				end
			end
			H_LOW: begin
				if (div_r == 8'h00) begin
					st_nxt = H_HIGH;
					sclk_nxt = 1'h1;
					if (idx_r >= 11'(fpid_hdr_clks(op_r))) begin
						rx_nxt = dual ? {rx_r[5:0], s2_r} : {rx_r[6:0], s2_r[1]};
						rxb_nxt = rxb_r + (dual ? 3'h2 : 3'h1);
						if (rxb_nxt == 3'h0) begin
							val_nxt = 1'h1;
							rd_nxt = rx_nxt;
						end
					end
				end
			end
			H_HIGH: begin
				if (div_r == 8'h00) begin
					sclk_nxt = 1'h0;
					idx_nxt = idx_r + 11'h001;
					hdr_nxt = shifted;
					st_nxt = (idx_nxt == total_r) ? H_TAIL : H_LOW;
					if (in_hdr_next && dual && idx_nxt >= 11'(OPCODE_CLKS)) begin
						{o1_nxt, o0_nxt} = shifted[39:38];
						oe1_nxt = 1'h1;
					end else if (in_hdr_next) begin
						o0_nxt = shifted[39];
					end else begin
						oe0_nxt = 1'h0;
						oe1_nxt = 1'h0;
					end
				end
			end
			H_TAIL: begin
				if (div_r == 8'h00) begin
					st_nxt = H_GAP;
					cs_n_nxt = 1'h1;
					oe0_nxt = 1'h0;
					oe1_nxt = 1'h0;
					gap_nxt = CS_HIGH_MIN_CYC;
					if (op_r == OP_SLEEP) begin
						gap_nxt = SLEEP_ENTRY_CYC + CS_HIGH_MIN_CYC;
					end else if (op_r == OP_WAKE_ID) begin
						gap_nxt = (total_r == 11'(OPCODE_CLKS) ? WAKE_CYC : WAKE_ID_CYC) +
							CS_HIGH_MIN_CYC;
					end
				end
			end
			H_GAP: begin
				gap_nxt = gap_r - 12'h001;
				if (gap_r == 12'h001) begin
					st_nxt = H_IDLE;
					done_nxt = 1'h1;
				end
			end
		endcase
		idle_nxt = st_nxt == H_IDLE;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_r <= H_IDLE;
			div_r <= 8'h00;
			idx_r <= '0;
			total_r <= '0;
			hdr_r <= '0;
			op_r <= 8'h00;
			rx_r <= 8'h00;
			rd_r <= 8'h00;
			rxb_r <= '0;
			gap_r <= '0;
			sclk_r <= 1'h0;
			cs_n_r <= 1'h1;
			o0_r <= 1'h0;
			o1_r <= 1'h0;
			oe0_r <= 1'h0;
			oe1_r <= 1'h0;
			idle_r <= 1'h1;
			val_r <= 1'h0;
			done_r <= 1'h0;
		end else begin
			st_r <= st_nxt;
			div_r <= div_nxt;
			idx_r <= idx_nxt;
			total_r <= total_nxt;
			hdr_r <= hdr_nxt;
			op_r <= op_nxt;
			rx_r <= rx_nxt;
			rd_r <= rd_nxt;
			rxb_r <= rxb_nxt;
			gap_r <= gap_nxt;
			sclk_r <= sclk_nxt;
			cs_n_r <= cs_n_nxt;
			o0_r <= o0_nxt;
			o1_r <= o1_nxt;
			oe0_r <= oe0_nxt;
			oe1_r <= oe1_nxt;
			idle_r <= idle_nxt;
			val_r <= val_nxt;
			done_r <= done_nxt;
		end
	end

	assign link.sclk = sclk_r;
	assign link.cs_n = cs_n_r;
	assign link.h_io0_o = o0_r;
	assign link.h_io0_oe = oe0_r;
	assign link.h_io1_o = o1_r;
	assign link.h_io1_oe = oe1_r;
	assign idle = idle_r;
	assign rd_valid = val_r;
	assign rd_data = rd_r;
	assign done = done_r;

endmodule : fpid_host

/* sim/fpid_link_sva.sv */
// Checker for the serial link between the flash identify ends.
// Assumes the bench feeds it the first link and the first flash end's flags.
`timescale 1ns/100ps
module fpid_link_sva
	import fpid_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic h_io0_o,
	input wire logic h_io0_oe,
	input wire logic d_io1_o,
	input wire logic d_io1_oe,
	input wire logic d_io0_oe,
	input wire logic asleep,
	input wire logic ready,
	input wire logic busy_flag
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	localparam int ENTRY_MAX = 312;
	logic [9:0] hi_cnt_r;
	logic [9:0] hi_cnt_nxt;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// Saturates so a long idle never wraps back below the wake figure
	always_comb begin
		hi_cnt_nxt = !cs_n ? 10'h000 : (&hi_cnt_r ? hi_cnt_r : hi_cnt_r + 10'h001);
	end
	always_ff @(posedge clock) begin
		if (!rst_n) hi_cnt_r <= 10'h000;
		else hi_cnt_r <= hi_cnt_nxt;
	end
	sequence s_gap;
		cs_n[*8];
	endsequence
	sequence s_wake_done;
		!ready ##1 ready;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	cs_gap_a: assert property ($rose(cs_n) |-> s_gap)
		else $error("chip select gap too short");
	dev_release_a: assert property (s_gap |-> !d_io1_oe && !d_io0_oe)
		else $error("device drives with chip select high");
	out_falling_a: assert property (d_io1_oe && $changed(d_io1_o) |-> !sclk)
		else $error("device data moved while clock high");
	host_change_a: assert property (h_io0_oe && $changed(h_io0_o) |-> !sclk)
		else $error("host data moved while clock high");
	idle_low_a: assert property ($fell(cs_n) |-> !sclk)
		else $error("clock not at idle level at frame start");
	entry_bound_a: assert property ($fell(ready) |-> ##[1:ENTRY_MAX] asleep)
		else $error("sleep not entered in time");
	asleep_blocks_a: assert property (asleep |-> !ready)
		else $error("ready while asleep");
	wake_delay_a: assert property (s_wake_done |-> {2'h0, hi_cnt_r} >= WAKE_CYC)
		else $error("ready before wake delay");
	busy_hold_a: assert property (busy_flag && asleep |=> asleep)
		else $error("woke while busy");
	reset_start_a: assert property ($rose(rst_n) |-> !asleep && ready)
		else $error("not normal after reset");
endmodule : fpid_link_sva

/* sim/tb_flash_powerdown_and_id_reader.sv */
// Bench for the flash identify link, host end against flash end.
// Assumes the design files are compiled first; a second link is hand driven.
`timescale 1ns/100ps
module tb_flash_powerdown_and_id_reader;
	import fpid_pkg::*;
	// ----------------------------------------------------------------
	// Setup
	// ----------------------------------------------------------------
	`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
		miscompares++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
	localparam logic [7:0] MFG_B = 8'hC3;
	localparam logic [7:0] DEV_B = 8'h2D;
	localparam logic [7:0] MT_B = 8'h30;
	localparam logic [7:0] CAP_B = 8'h10;
	localparam logic [63:0] UID_V = 64'h0123456789ABCDEF;
	localparam logic [103:0] ROWS [7] = '{
		{OP_WAKE_ID, 24'h000000, 8'h02, DEV_B, DEV_B, 48'h0},
		{OP_MFG_ID, 24'h000000, 8'h03, MFG_B, DEV_B, MFG_B, 40'h0},
		{OP_MFG_ID, ADDR_SWAP, 8'h03, DEV_B, MFG_B, DEV_B, 40'h0},
		{OP_MFG_ID_DUAL, 24'h000000, 8'h03, MFG_B, DEV_B, MFG_B, 40'h0},
		{OP_MFG_ID_DUAL, ADDR_SWAP, 8'h02, DEV_B, MFG_B, 48'h0},
		{OP_UNIQUE, 24'h000000, 8'h08, UID_V},
		{OP_STD_ID, 24'h000000, 8'h08, MFG_B, MT_B, CAP_B, 40'h0}};
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic busy = 1'h0;
	logic req = 1'h0;
	logic [7:0] req_op = 8'h00;
	logic [23:0] req_addr = 24'h000000;
	logic [7:0] req_nbytes = 8'h00;
	logic idle, rd_valid, done, asleep, ready, busy_flag, asleep2, ready2;
	logic [7:0] rd_data;
	int miscompares = 0;
	int checks_done = 0;
	int cyc = 0;
	int c;
	int hi1 = 0;
	int rise1 = 0;
	logic ready_q = 1'h1;
	fpid_if lk1();
	fpid_if lk2();
	fpid_device #(.MANUF_ID(MFG_B), .DEVICE_ID(DEV_B), .MEMORY_TYPE_BYTE(MT_B),
		.CAPACITY_BYTE(CAP_B), .UNIQUE_ID(UID_V)) fpid_device_inst (.clock(clock),
		.rst_n(rst_n), .link(lk1), .busy(busy), .asleep(asleep), .ready(ready),
		.busy_flag(busy_flag));
	fpid_device #(.MANUF_ID(MFG_B), .DEVICE_ID(DEV_B), .MEMORY_TYPE_BYTE(MT_B),
		.CAPACITY_BYTE(CAP_B), .UNIQUE_ID(UID_V)) fpid_device_inst_2 (.clock(clock),
		.rst_n(rst_n), .link(lk2), .busy(1'h0), .asleep(asleep2), .ready(ready2),
		.busy_flag());
	fpid_host #(.DIV_HALF(8)) fpid_host_inst (.clock(clock), .rst_n(rst_n), .link(lk1),
		.req(req), .req_op(req_op), .req_addr(req_addr), .req_nbytes(req_nbytes),
		.idle(idle), .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
	fpid_link_sva fpid_link_sva_inst (.clock(clock), .rst_n(rst_n), .sclk(lk1.sclk),
		.cs_n(lk1.cs_n), .h_io0_o(lk1.h_io0_o), .h_io0_oe(lk1.h_io0_oe),
		.d_io1_o(lk1.d_io1_o), .d_io1_oe(lk1.d_io1_oe), .d_io0_oe(lk1.d_io0_oe),
		.asleep(asleep), .ready(ready), .busy_flag(busy_flag));
	always #5 clock = ~clock;
	initial begin
		lk2.sclk = 1'h0;
		lk2.cs_n = 1'h1;
		lk2.h_io0_o = 1'h0;
		lk2.h_io0_oe = 1'h0;
		lk2.h_io1_o = 1'h0;
		lk2.h_io1_oe = 1'h0;
	end
	// Cuts a hang well past the longest expected run
	// Also notes how long chip select stood high when the first flash end turns ready
	always @(posedge clock) begin
		cyc++;
		hi1 = (lk1.cs_n === 1'h1) ? hi1 + 1 : 0;
		if (ready === 1'h1 && ready_q !== 1'h1) rise1 = hi1;
		ready_q = ready;
		if (cyc == 40000) begin
			miscompares++;
			report_and_stop();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick
	task automatic run(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] n,
		input logic [63:0] ex, input string nm);
		int i, t;
		i = 0;
		t = 0;
		req = 1'h1;
		req_op = op;
		req_addr = ad;
		req_nbytes = n;
		tick();
		req = 1'h0;
		while (done !== 1'h1 && t < 20000) begin
			if (rd_valid === 1'h1) begin
				`CHK(nm, ex[63 - 8 * i -: 8], rd_data)
				i++;
			end
			tick();
			t++;
		end
		if (t >= 20000) miscompares++;
		`CHK(nm, n, i[7:0])
		`CHK("idle_done", 1'h1, idle)
	endtask : run
	task automatic wait_sig(ref logic s, output int n);
		n = 0;
		while (s !== 1'h1 && n < 1000) begin
			tick();
			n++;
		end
		if (s !== 1'h1) miscompares++;
	endtask : wait_sig
	// Hand driven frame, so the bit count can be wrong on purpose
	task automatic frame2(input logic [7:0] op, input int nclk);
		lk2.cs_n = 1'h0;
		lk2.h_io0_oe = 1'h1;
		for (int b = 0; b < nclk; b++) begin
			lk2.h_io0_o = op[7 - (b % 8)];
			repeat (8) tick();
			lk2.sclk = 1'h1;
			repeat (8) tick();
			lk2.sclk = 1'h0;
		end
		repeat (8) tick();
		lk2.cs_n = 1'h1;
		lk2.h_io0_oe = 1'h0;
		repeat (12) tick();
	endtask : frame2
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) tick();
		rst_n = 1'h1;
		`CHK("ready_rst", 1'h1, ready)
		`CHK("asleep_rst", 1'h0, asleep)
		for (int k = 0; k < 7; k++) begin
			wait_sig(ready, c);
			run(ROWS[k][103:96], ROWS[k][95:72], ROWS[k][71:64], ROWS[k][63:0], "row");
		end
		run(OP_SLEEP, 24'h000000, 8'h00, 64'h0, "sleep");
		wait_sig(asleep, c);
		`CHK("entry_time", 1'h1, c <= int'(SLEEP_ENTRY_CYC))
		run(OP_STD_ID, 24'h000000, 8'h02, {16'hFFFF, 48'h0}, "asleep_std");
		`CHK("still_asleep", 1'h1, asleep)
		busy = 1'h1;
		tick();
		`CHK("busy_flag", 1'h1, busy_flag)
		run(OP_WAKE_ID, 24'h000000, 8'h01, {8'hFF, 56'h0}, "busy_wake");
		busy = 1'h0;
		tick();
		`CHK("busy_asleep", 1'h1, asleep)
		`CHK("busy_clear", 1'h0, busy_flag)
		run(OP_WAKE_ID, 24'h000000, 8'h01, {DEV_B, 56'h0}, "wake_id");
		wait_sig(ready, c);
		// The host holds the long gap, so ready is judged against chip select's high time
		`CHK("id_wake_time", 1'h1, rise1 >= int'(WAKE_ID_CYC) && rise1 <= int'(WAKE_ID_CYC) + 8)
		`CHK("awake", 1'h0, asleep)
		frame2(OP_SLEEP, 9);
		repeat (330) tick();
		`CHK("long_sleep", 1'h0, asleep2)
		frame2(OP_SLEEP, 8);
		wait_sig(asleep2, c);
		`CHK("sleep2", 1'h1, asleep2)
		frame2(OP_WAKE_ID, 8);
		wait_sig(ready2, c);
		`CHK("wake_time", 1'h1, c >= int'(WAKE_CYC) - 24 && c <= int'(WAKE_CYC))
		frame2(OP_SLEEP, 8);
		wait_sig(asleep2, c);
		rst_n = 1'h0;
		repeat (3) tick();
		rst_n = 1'h1;
		tick();
		`CHK("mid_rst_asleep", 1'h0, asleep2)
		`CHK("mid_rst_ready", 1'h1, ready2)
		`CHK("mid_rst_cs", 1'h1, lk1.cs_n)
		report_and_stop();
	end
endmodule : tb_flash_powerdown_and_id_reader
